// file: rtl/pcs_cfg.svh
// Address map, field positions and reset values of the clock select block
// Included by the design and the testbench; definitions only
`ifndef PCS_CFG_SVH
`define PCS_CFG_SVH
`define PCS_LPMCU_ADDR   32'h4000b018
`define PCS_AON_ADDR     32'h4000f00c
`define PCS_LPMCU_RESET  32'h00303100
`define PCS_LPMCU_MASK   32'hfff9333f
`define PCS_AON_RESET    24'h010000
`define PCS_AON_MASK     24'h3fc07e
`define PCS_SLEEP_GATE   16
`define PCS_XO_BYPASS    21
`define PCS_XO_OFF       20
`define PCS_WAKE_INV     19
`define PCS_SEQ_RTC      18
`define PCS_SLOW_OUT     17
`define PCS_TB_2M        15
`define PCS_SEQ_2M       14
`define PCS_RST_VAL      6
`define PCS_RST_EN       5
`define PCS_BOOT_REGS    4
`define PCS_BOOT_MUX     3
`define PCS_ST_EXT       2
`define PCS_ST_RTC       1
`define PCS_POL          31
`define PCS_PHA          30
`define PCS_UART_B_INV   29
`define PCS_UART_A_INV   28
`define PCS_DIV_HI       27
`define PCS_DIV_LO       20
`define PCS_RAM_BYP      19
`define PCS_DIV_SEL      16
`define PCS_FL_HI        13
`define PCS_FL_LO        12
`define PCS_CAL_XO       9
`define PCS_WIC_BYP      8
`define PCS_TM_HI        5
`define PCS_TM_LO        4
`define PCS_LP_CLK       3
`define PCS_R26          2
`define PCS_CPU_HI       1
`define PCS_CPU_LO       0
`define PCS_LADDER_LAST  3'h7
`endif

// file: rtl/pcs_pkg.sv
// Types shared by the clock select block
// Assumes pcs_cfg.svh is on the include path
package pcs_pkg;
  // Divide exponent on the fixed ladder: rate is 26 MHz over 2**exp
  typedef logic [1:0] pcs_rate_type;
  typedef logic [3:0] pcs_be_type;
endpackage

// file: rtl/pcs_clock_select.sv
// Peripheral clock select: register file on Avalon-MM and clock strobe logic
// Assumes ref_tick pulses once per 26 MHz source period, synchronous to clock
// Operation
// - The sleep timer clock runs only while its gate bit in the always-on register is 1.
// - Bit 29 set inverts the second UART interface clock, clear passes it unchanged.
// - Bit 28 set inverts the first UART interface clock, clear passes it unchanged.
// - Bits 27:20 hold an eight-bit value that divides the flash clock when divided mode is on.
// - The programmable flash divider counts periods of the 26 MHz source.
// - Bit 16 set routes the divider to the flash clock, clear routes the fixed ladder.
// - Flash select codes 0 to 3 give 3.25, 6.5, 13 and 26 MHz.
// - Timer select codes 0 to 3 give 26, 13, 6.5 and 3.25 MHz.
// - Both halves of the dual timer share one selected clock.
// - Bit 31 stores the external serial polarity mode, 1 enables it.
// - Bit 30 stores the external serial phase mode, 1 enables it.
// - The control register resets to 0x00303100, giving 26 MHz flash and divide value 3.
// - The remaining internal bits are plain read/write storage driving their controls.
`timescale 1ns/1ps
`include "pcs_cfg.svh"
module pcs_clock_select #(
  parameter int DIV_WIDTH = 8                 // Width of the flash divide value
) (
  input  wire logic              clock,                           // 125 MHz
  input  wire logic              rst_b,                           // Async reset
  input  wire logic [31:0]       avs_address,                     // Byte address
  input  wire logic              avs_read,                        // Read request
  input  wire logic              avs_write,                       // Write request
  input  wire logic [31:0]       avs_writedata,                   // Write data
  input  wire pcs_pkg::pcs_be_type avs_byteenable,                // Byte lanes
  output logic [31:0]            avs_readdata,                    // Read data
  output logic                   avs_waitrequest,                 // Stall
  input  wire logic              ref_tick,                        // 26 MHz period
  input  wire logic              uart_a_clock_in,                 // UART A clock
  input  wire logic              uart_b_clock_in,                 // UART B clock
  output logic                   uart_a_clock_out,                // To UART A
  output logic                   uart_b_clock_out,                // To UART B
  output logic                   flash_clock_strobe,              // Flash tick
  output logic                   paired_timer_clock_strobe,       // Both timers
  output logic                   sleep_timer_clock_gate,          // Gate enable
  output logic                   external_serial_polarity_mode,   // Mode bit
  output logic                   external_serial_phase_mode,      // Mode bit
  output logic                   data_ram_bypass_enable,          // Internal
  output logic                   calibration_crystal_clock_use,   // Internal
  output logic                   wake_controller_bypass,          // Internal
  output logic                   core_low_power_clock_use,        // Internal
  output logic                   radio_26mhz_clock_use,           // Internal
  output logic [1:0]             cpu_clock_source_select,         // Internal
  output logic                   crystal_bypass_force,            // Internal
  output logic                   crystal_shutoff_force,           // Internal
  output logic                   wake_pin_invert,                 // Internal
  output logic                   sequencer_rtc_clock_use,         // Internal
  output logic                   slow_clock_output_enable,        // Internal
  output logic                   timebase_2mhz_select,            // Internal
  output logic                   sequencer_2mhz_clock_use,        // Internal
  output logic                   cpu_reset_override_value,        // Internal
  output logic                   cpu_reset_override_enable,       // Internal
  output logic                   boot_register_use,               // Internal
  output logic                   boot_reset_source_select,        // Internal
  output logic                   sleep_timer_external_slow_clock, // Internal
  output logic                   sleep_timer_rtc_slow_clock       // Internal
);
  import pcs_pkg::*;

  // Ladder strobe for a divide exponent, given the free running ladder count
  function automatic logic rate_hit(input pcs_rate_type e, input logic [2:0] c);
    logic h;
    h = 1'b0;
    unique case (e)
      2'h0: h = 1'b1;
      2'h1: h = c[0];
      2'h2: h = &c[1:0];
      2'h3: h = &c;
    endcase
    return h;
  endfunction

  // Byte-lane merge, reserved bits forced to zero
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input pcs_be_type be, input logic [31:0] m);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r & m;
  endfunction

  logic [31:0]          lp_reg, lp_next;
  logic [23:0]          aon_reg, aon_next;
  logic [31:0]          rdata_reg, rdata_next;
  logic                 wait_reg, wait_next;
  logic [2:0]           ladder_reg, ladder_next;
  logic [DIV_WIDTH-1:0] div_cnt_reg, div_cnt_next;
  logic                 src_reg, src_next;
  pcs_rate_type         fl_rate_reg, fl_rate_next;
  pcs_rate_type         tm_rate_reg, tm_rate_next;
  logic                 fl_stb_reg, fl_stb_next;
  logic                 tm_stb_reg, tm_stb_next;
  logic [1:0]           inv_reg, inv_next;
  logic [1:0]           prev_reg, prev_next;
  logic [1:0]           uclk_reg, uclk_next;
  logic                 req, accept, hit_lp, hit_aon;
  logic                 lad_wrap, div_hit, fixed_hit, flash_hit;
  logic [DIV_WIDTH-1:0] div_value;
  logic [1:0]           uart_in, uart_rise, inv_bits;

  assign req       = avs_read | avs_write;
  assign accept    = req & ~wait_reg;
  assign hit_lp    = avs_address == `PCS_LPMCU_ADDR;
  assign hit_aon   = avs_address == `PCS_AON_ADDR;
  assign div_value = lp_reg[`PCS_DIV_HI:`PCS_DIV_LO];
  assign uart_in   = {uart_b_clock_in, uart_a_clock_in};
  assign inv_bits  = {lp_reg[`PCS_UART_B_INV], lp_reg[`PCS_UART_A_INV]};
  assign uart_rise = uart_in & ~prev_reg;

  // Register file: one wait state, write lands on the edge after the wait, which ends the transfer
  always_comb begin
    lp_next    = lp_reg;
    aon_next   = aon_reg;
    rdata_next = rdata_reg;
    wait_next  = 1'b1;
    if (req && wait_reg) begin
      wait_next = 1'b0;
      rdata_next = 32'h0;
      if (hit_lp) begin
        rdata_next = lp_reg;
      end else if (hit_aon) begin
        rdata_next = {8'h0, aon_reg};
      end
    end
    if (accept && avs_write && hit_lp) begin
      lp_next = merge(lp_reg, avs_writedata, avs_byteenable, `PCS_LPMCU_MASK);
    end
    if (accept && avs_write && hit_aon) begin
      aon_next = 24'(merge({8'h0, aon_reg}, avs_writedata, avs_byteenable,
                           {8'h0, `PCS_AON_MASK}));
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      lp_reg    <= `PCS_LPMCU_RESET;
      aon_reg   <= `PCS_AON_RESET;
      rdata_reg <= 32'h0;
      wait_reg  <= 1'b1;
    end else begin
      lp_reg    <= lp_next;
      aon_reg   <= aon_next;
      rdata_reg <= rdata_next;
      wait_reg  <= wait_next;
    end
  end

  // Ladder and divider both count source periods
  assign lad_wrap  = ref_tick && ladder_reg == `PCS_LADDER_LAST;
  assign div_hit   = ref_tick && ({1'b0, div_cnt_reg} + 1'b1 >= {1'b0, div_value});
  assign fixed_hit = ref_tick && rate_hit(fl_rate_reg, ladder_reg);
  assign flash_hit = src_reg ? div_hit : fixed_hit;

  // Selects are taken only where the old and new periods both end, so no runt
  always_comb begin
    ladder_next  = ref_tick ? ladder_reg + 3'h1 : ladder_reg;
    div_cnt_next = div_cnt_reg;
    if (div_hit) begin
      div_cnt_next = '0;
    end else if (ref_tick) begin
      div_cnt_next = div_cnt_reg + 1'b1;
    end
    src_next     = src_reg;
    fl_rate_next = fl_rate_reg;
    tm_rate_next = tm_rate_reg;
    if (lad_wrap) begin
      fl_rate_next = ~lp_reg[`PCS_FL_HI:`PCS_FL_LO];
      tm_rate_next = lp_reg[`PCS_TM_HI:`PCS_TM_LO];
    end
    if (!src_reg && lp_reg[`PCS_DIV_SEL] && fixed_hit) begin
      src_next     = 1'b1;
      div_cnt_next = '0;
    end else if (src_reg && !lp_reg[`PCS_DIV_SEL] && div_hit && lad_wrap) begin
      src_next = 1'b0;
    end
    fl_stb_next = flash_hit;
    tm_stb_next = ref_tick && rate_hit(tm_rate_reg, ladder_reg);
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ladder_reg  <= 3'h0;
      div_cnt_reg <= '0;
      src_reg     <= 1'b0;
      fl_rate_reg <= 2'h0;
      tm_rate_reg <= 2'h0;
      fl_stb_reg  <= 1'b0;
      tm_stb_reg  <= 1'b0;
    end else begin
      ladder_reg  <= ladder_next;
      div_cnt_reg <= div_cnt_next;
      src_reg     <= src_next;
      fl_rate_reg <= fl_rate_next;
      tm_rate_reg <= tm_rate_next;
      fl_stb_reg  <= fl_stb_next;
      tm_stb_reg  <= tm_stb_next;
    end
  end

  // Inversion changes only on a rising input edge, which stretches one phase
  always_comb begin
    prev_next = uart_in;
    inv_next  = inv_reg;
    for (int i = 0; i < 2; i++) begin
      if (uart_rise[i]) begin
        inv_next[i] = inv_bits[i];
      end
    end
    uclk_next = uart_in ^ inv_next;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      prev_reg <= 2'h0;
      inv_reg  <= 2'h0;
      uclk_reg <= 2'h0;
    end else begin
      prev_reg <= prev_next;
      inv_reg  <= inv_next;
      uclk_reg <= uclk_next;
    end
  end

  // Outputs are register bits or registered strobes
  assign avs_readdata                    = rdata_reg;
  assign avs_waitrequest                 = wait_reg;
  assign uart_a_clock_out                = uclk_reg[0];
  assign uart_b_clock_out                = uclk_reg[1];
  assign flash_clock_strobe              = fl_stb_reg;
  assign paired_timer_clock_strobe       = tm_stb_reg;
  assign sleep_timer_clock_gate          = aon_reg[`PCS_SLEEP_GATE];
  assign external_serial_polarity_mode   = lp_reg[`PCS_POL];
  assign external_serial_phase_mode      = lp_reg[`PCS_PHA];
  assign data_ram_bypass_enable          = lp_reg[`PCS_RAM_BYP];
  assign calibration_crystal_clock_use   = lp_reg[`PCS_CAL_XO];
  assign wake_controller_bypass          = lp_reg[`PCS_WIC_BYP];
  assign core_low_power_clock_use        = lp_reg[`PCS_LP_CLK];
  assign radio_26mhz_clock_use           = lp_reg[`PCS_R26];
  assign cpu_clock_source_select         = lp_reg[`PCS_CPU_HI:`PCS_CPU_LO];
  assign crystal_bypass_force            = aon_reg[`PCS_XO_BYPASS];
  assign crystal_shutoff_force           = aon_reg[`PCS_XO_OFF];
  assign wake_pin_invert                 = aon_reg[`PCS_WAKE_INV];
  assign sequencer_rtc_clock_use         = aon_reg[`PCS_SEQ_RTC];
  assign slow_clock_output_enable        = aon_reg[`PCS_SLOW_OUT];
  assign timebase_2mhz_select            = aon_reg[`PCS_TB_2M];
  assign sequencer_2mhz_clock_use        = aon_reg[`PCS_SEQ_2M];
  assign cpu_reset_override_value        = aon_reg[`PCS_RST_VAL];
  assign cpu_reset_override_enable       = aon_reg[`PCS_RST_EN];
  assign boot_register_use               = aon_reg[`PCS_BOOT_REGS];
  assign boot_reset_source_select        = aon_reg[`PCS_BOOT_MUX];
  assign sleep_timer_external_slow_clock = aon_reg[`PCS_ST_EXT];
  assign sleep_timer_rtc_slow_clock      = aon_reg[`PCS_ST_RTC];

  // Checks
  sequence s_aon_write;
    accept && avs_write && hit_aon && avs_byteenable[2];
  endsequence
  sequence s_lp_write;
    accept && avs_write && hit_lp && (&avs_byteenable);
  endsequence

  a_sleep_gate_follow: assert property (@(posedge clock) disable iff (!rst_b)
    s_aon_write |=> sleep_timer_clock_gate == $past(avs_writedata[`PCS_SLEEP_GATE]))
    else $error("sleep gate did not follow write");
  a_uart_b_invert: assert property (@(posedge clock) disable iff (!rst_b)
    inv_reg[1] && uart_rise[1] ##1 uart_b_clock_in |=> !uart_b_clock_out)
    else $error("uart b clock not inverted");
  a_uart_a_pass: assert property (@(posedge clock) disable iff (!rst_b)
    !inv_reg[0] && !uart_rise[0] && uart_a_clock_in |=> uart_a_clock_out)
    else $error("uart a clock not passed");
  a_div_strobe: assert property (@(posedge clock) disable iff (!rst_b)
    src_reg && div_hit |=> flash_clock_strobe)
    else $error("divided flash strobe missing");
  a_flash_full_rate: assert property (@(posedge clock) disable iff (!rst_b)
    !src_reg && fl_rate_reg == 2'h0 && ref_tick |=> flash_clock_strobe)
    else $error("26 MHz flash strobe missing");
  a_timer_slow_rate: assert property (@(posedge clock) disable iff (!rst_b)
    tm_rate_reg == 2'h3 && ref_tick && ladder_reg != `PCS_LADDER_LAST
    |=> !paired_timer_clock_strobe)
    else $error("timer strobe too fast");
  a_lp_storage: assert property (@(posedge clock) disable iff (!rst_b)
    s_lp_write |=> lp_reg == ($past(avs_writedata) & `PCS_LPMCU_MASK))
    else $error("control register not stored");
  a_rate_switch_edge: assert property (@(posedge clock) disable iff (!rst_b)
    $changed(tm_rate_reg) |-> $past(lad_wrap))
    else $error("timer rate changed mid period");
  a_wait_one_cycle: assert property (@(posedge clock) disable iff (!rst_b)
    req && wait_reg |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer timing wrong");
  a_flash_rate_edge: assert property (@(posedge clock) disable iff (!rst_b)
    $changed(fl_rate_reg) |-> $past(lad_wrap))
    else $error("flash rate changed mid period");
  a_fixed_return_edge: assert property (@(posedge clock) disable iff (!rst_b)
    $fell(src_reg) |-> $past(div_hit) && $past(lad_wrap))
    else $error("flash source left divider mid period");
  a_unmapped_zero: assert property (@(posedge clock) disable iff (!rst_b)
    req && wait_reg && !hit_lp && !hit_aon |=> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
endmodule

// file: tb/testbench.sv
// Self-checking bench for the peripheral clock select block
// Assumes rtl/ is on the include path and pcs_pkg is compiled first
`timescale 1ns/1ps
`include "pcs_cfg.svh"
module testbench;
  import pcs_pkg::*;
  logic        clock           = 1'b0;
  logic        rst_b           = 1'b0;
  logic [31:0] avs_address     = 32'h0;
  logic        avs_read        = 1'b0;
  logic        avs_write       = 1'b0;
  logic [31:0] avs_writedata   = 32'h0;
  pcs_be_type  avs_byteenable  = 4'hf;
  logic        ref_tick        = 1'b0;
  logic        uart_a_clock_in = 1'b0;
  logic        uart_b_clock_in = 1'b0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        uart_a_out;
  logic        uart_b_out;
  logic        flash_strobe;
  logic        timer_strobe;
  logic [31:0] lp_o;              // Control-register outputs at their bit positions
  logic [23:0] aon_o;             // Always-on outputs at their bit positions
  logic        flash_prev;
  logic        timer_prev;
  int          runts       = 0;
  int          miscompares = 0;
  int          checked     = 0;
  int          fper        = 2;   // Flash strobe period in cycles before a select change
  int          tper        = 2;   // Timer strobe period in cycles before a select change
  localparam logic [31:0] LP_OUTS = 32'hc008030f;

  pcs_clock_select i_pcs_clock_select (
    .clock(clock), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ref_tick(ref_tick),
    .uart_a_clock_in(uart_a_clock_in), .uart_b_clock_in(uart_b_clock_in),
    .uart_a_clock_out(uart_a_out), .uart_b_clock_out(uart_b_out),
    .flash_clock_strobe(flash_strobe), .paired_timer_clock_strobe(timer_strobe),
    .sleep_timer_clock_gate(aon_o[16]), .external_serial_polarity_mode(lp_o[31]),
    .external_serial_phase_mode(lp_o[30]), .data_ram_bypass_enable(lp_o[19]),
    .calibration_crystal_clock_use(lp_o[9]), .wake_controller_bypass(lp_o[8]),
    .core_low_power_clock_use(lp_o[3]), .radio_26mhz_clock_use(lp_o[2]),
    .cpu_clock_source_select(lp_o[1:0]), .crystal_bypass_force(aon_o[21]),
    .crystal_shutoff_force(aon_o[20]), .wake_pin_invert(aon_o[19]),
    .sequencer_rtc_clock_use(aon_o[18]), .slow_clock_output_enable(aon_o[17]),
    .timebase_2mhz_select(aon_o[15]), .sequencer_2mhz_clock_use(aon_o[14]),
    .cpu_reset_override_value(aon_o[6]), .cpu_reset_override_enable(aon_o[5]),
    .boot_register_use(aon_o[4]), .boot_reset_source_select(aon_o[3]),
    .sleep_timer_external_slow_clock(aon_o[2]), .sleep_timer_rtc_slow_clock(aon_o[1])
  );

  // 125 MHz clock
  always #4 clock = ~clock;

  // Source tick every second cycle, so a runt shows as two adjacent strobes
  always @(posedge clock) begin
    ref_tick <= rst_b ? ~ref_tick : 1'b0;
    if (flash_strobe === 1'b1 && flash_prev === 1'b1) runts++;
    if (timer_strobe === 1'b1 && timer_prev === 1'b1) runts++;
    flash_prev <= flash_strobe;
    timer_prev <= timer_strobe;
  end

  task automatic tally_and_finish;
    if (miscompares == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One transfer; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] data,
                     input pcs_be_type be, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clock);
    avs_address <= addr;
    avs_writedata <= data;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      miscompares++;
      tally_and_finish();
    end
  endtask

  task automatic wr(input logic [31:0] addr, input logic [31:0] data, input pcs_be_type be);
    logic [31:0] rd;
    bus(1'b1, addr, data, be, rd);
  endtask

  task automatic rd_chk(input string what, input logic [31:0] addr, input logic [31:0] exp);
    logic [31:0] rd;
    bus(1'b0, addr, 32'h0, 4'hf, rd);
    check(what, rd, exp);
  endtask

  // Inversion is only adopted on a rising input, so the first step is not judged
  task automatic uart(input logic ia, input logic ib);
    wr(`PCS_LPMCU_ADDR, 32'h00303100 | {2'b00, ib, ia, 28'h0}, 4'hf);
    for (int k = 0; k < 4; k++) begin
      uart_a_clock_in <= k[0];
      uart_b_clock_in <= ~k[0];
      repeat (2) @(posedge clock);
      if (k > 0) begin
        check("uart a clock", {31'h0, uart_a_out}, {31'h0, k[0] ^ ia});
        check("uart b clock", {31'h0, uart_b_out}, {31'h0, ~k[0] ^ ib});
      end
    end
  endtask

  // 160 counted cycles hold 80 ticks, a whole number of ladder and divider periods;
  // across the switch no strobe gap may undercut the faster of the old and new periods
  task automatic rates(input logic [31:0] lp, input int fexp, input int texp);
    int         f;
    int         t;
    int         g[2];
    int         mg[2];
    int         lo[2];
    logic [1:0] s;
    f = 0;
    t = 0;
    g = '{0, 0};
    mg = '{1000, 1000};
    lo[0] = fper < 160 / fexp ? fper : 160 / fexp;
    lo[1] = tper < 160 / texp ? tper : 160 / texp;
    wr(`PCS_LPMCU_ADDR, lp, 4'hf);
    for (int i = 0; i < 208; i++) begin
      @(posedge clock);
      s = {timer_strobe === 1'b1, flash_strobe === 1'b1};
      if (i >= 48 && s[0]) f++;
      if (i >= 48 && s[1]) t++;
      for (int j = 0; j < 2; j++) begin
        if (s[j] && g[j] > 0 && g[j] < mg[j]) mg[j] = g[j];
        if (s[j]) g[j] = 1;
        else if (g[j] > 0) g[j]++;
      end
    end
    check("flash strobes", 32'(f), 32'(fexp));
    check("timer strobes", 32'(t), 32'(texp));
    check("flash switch gap", {31'h0, mg[0] >= lo[0]}, 32'h1);
    check("timer switch gap", {31'h0, mg[1] >= lo[1]}, 32'h1);
    fper = 160 / fexp;
    tper = 160 / texp;
  endtask

  initial begin
    repeat (3) @(posedge clock);
    check("waitrequest in reset", {31'h0, avs_waitrequest}, 32'h1);
    rst_b <= 1'b1;
    rd_chk("lp reset", `PCS_LPMCU_ADDR, 32'h00303100);
    rd_chk("aon reset", `PCS_AON_ADDR, 32'h00010000);
    check("lp outputs reset", lp_o & LP_OUTS, 32'h00000100);
    check("aon outputs reset", {8'h0, aon_o & 24'h3fc07e}, 32'h00010000);
    wr(`PCS_LPMCU_ADDR, 32'hffffffff, 4'hf);
    rd_chk("lp all ones", `PCS_LPMCU_ADDR, 32'hfff9333f);
    check("lp outputs set", lp_o & LP_OUTS, LP_OUTS);
    wr(`PCS_AON_ADDR, 32'hffffffff, 4'hf);
    rd_chk("aon all ones", `PCS_AON_ADDR, 32'h003fc07e);
    check("aon outputs set", {8'h0, aon_o & 24'h3fc07e}, 32'h003fc07e);
    wr(`PCS_AON_ADDR, 32'h0, 4'hf);
    @(posedge clock); // The write lands on the edge that ends it, so look one edge later
    check("aon outputs clear", {8'h0, aon_o & 24'h3fc07e}, 32'h0);
    wr(32'h4000b01c, 32'h0, 4'hf);
    rd_chk("unmapped read", 32'h4000b01c, 32'h0);
    wr(`PCS_LPMCU_ADDR, 32'h0, 4'h1);
    rd_chk("lp lane write", `PCS_LPMCU_ADDR, 32'hfff93300);
    uart(1'b0, 1'b0);
    uart(1'b1, 1'b0);
    uart(1'b0, 1'b1);
    uart(1'b1, 1'b1);
    // Flash code c and timer code c together: rates move in opposite directions
    for (int c = 0; c < 4; c++) begin
      rates(32'h00300000 | (c << 12) | (c << 4), 80 >> (3 - c), 80 >> c);
    end
    rates(32'h00510000, 16, 80);
    rates(32'h00110000, 80, 80);
    // A second reset mid-run must restore the defaults over any written state
    rst_b <= 1'b0;
    repeat (2) @(posedge clock);
    check("waitrequest in second reset", {31'h0, avs_waitrequest}, 32'h1);
    rst_b <= 1'b1;
    rd_chk("lp second reset", `PCS_LPMCU_ADDR, 32'h00303100);
    rd_chk("aon second reset", `PCS_AON_ADDR, 32'h00010000);
    check("runt strobes", 32'(runts), 32'h0);
    tally_and_finish();
  end
endmodule
